//--- rtl/omed_addr_gen.sv
`timescale 1ns/1ns
`default_nettype none
module omed_addr_gen (
    omed_addr_if.gen ai // Operand address request and answer.
);
    always_comb begin
        ai.indexed = 1'b0;
        if (ai.a) begin
            ai.addr = {ai.bank, ai.f};
        end else if (ai.ext_en && (ai.f <= omed_pkg::ACCESS_LIMIT)) begin
            ai.indexed = 1'b1;
            ai.addr = ai.ptr2 + {4'h0, ai.f};
        end else if (ai.f <= omed_pkg::ACCESS_LIMIT) begin
            ai.addr = {4'h0, ai.f};
        end else begin
            ai.addr = {omed_pkg::ACCESS_HIGH_BANK, ai.f};
        end
    end
endmodule
`default_nettype wire

//--- rtl/omed_addr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface omed_addr_if;
    logic [7:0] f;
    logic a;
    logic ext_en;
    logic [3:0] bank;
    logic [11:0] ptr2;
    logic [11:0] addr;
    logic indexed;
    modport core (output f, a, ext_en, bank, ptr2, input addr, indexed);
    modport gen (input f, a, ext_en, bank, ptr2, output addr, indexed);
endinterface
`default_nettype wire

//--- rtl/omed_core.sv
// Overview of operation
// - OR accumulator with data byte; d=0 writes accumulator, d=1 the byte.
// - Extension on, a=0, operand at most 5Fh: indexed from pointer two.
// - Unsigned accumulator times literal into product pair, high byte upper.
// - Unsigned accumulator times data byte into product pair; a picks bank.
// - Multiplies leave every status flag alone.
// - Register multiply keeps accumulator and data byte unchanged.
// - Extension enabled by default; fuse bit enables or disables it.
// - Extension adds eight instructions, pointer literal ones and a call, to the standard set.
// - Add literal to chosen pointer; field 11 adds to two and returns.
// - Subtract literal from pointer; field 11 uses two and returns.
// - Call to target built from accumulator, two cycles, no flags.
// - Store literal at pointer two then decrement it, one cycle.
// - Two-word move, source pointer two offset, 12-bit destination.
// - Two-word move, source and destination both pointer two offsets.
`timescale 1ns/1ns
`default_nettype none
module omed_core #(
    parameter int DMEM_AW = 12,
    parameter int STACK_DEPTH = 8
) (
    input wire logic I_SYS_CLK, // Core clock.
    input wire logic I_NRST, // Asynchronous reset, active low.
    input wire logic I_EXT_FUSE, // Extension fuse, high enables.
    input wire logic I_INSTR_VALID, // Instruction word valid.
    input wire logic [15:0] I_INSTR, // Instruction word.
    output logic O_INSTR_READY, // Word taken when valid.
    output logic [15:0] O_PC, // Program counter.
    output logic O_EXT_ENABLED, // Extension in force.
    input wire logic I_HSEL, // AHB select.
    input wire logic [31:0] I_HADDR, // AHB address.
    input wire logic [1:0] I_HTRANS, // AHB transfer type.
    input wire logic I_HWRITE, // AHB write.
    input wire logic [2:0] I_HSIZE, // AHB size, word only.
    input wire logic [31:0] I_HWDATA, // AHB write data.
    input wire logic I_HREADY, // AHB bus ready.
    output logic [31:0] O_HRDATA, // AHB read data.
    output logic O_HREADYOUT, // AHB slave ready.
    output logic O_HRESP // AHB response.
);
    localparam int DMEM_DEPTH = 1 << DMEM_AW;
    localparam int STK_AW = $clog2(STACK_DEPTH);
    localparam logic [STK_AW-1:0] STK_ONE = {{(STK_AW-1){1'b0}}, 1'b1};

    generate
        if (DMEM_AW != omed_pkg::ADDR_W) begin : g_bad_aw
            $error("DMEM_AW must equal the 12-bit data address width");
        end
        if (STACK_DEPTH < 2 || (1 << STK_AW) != STACK_DEPTH) begin : g_bad_sd
            $error("STACK_DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [7:0] dmem [DMEM_DEPTH];
    logic [15:0] stk_mem [STACK_DEPTH];

    omed_pkg::omed_state_t state_q, state_d;
    logic [7:0] acc_q, acc_d, bank_q, bank_d, call_hi_q, call_hi_d;
    logic [7:0] product_high_byte_q, product_high_byte_d, product_low_byte_q, product_low_byte_d;
    logic [2:0][11:0] ptr_q, ptr_d;
    logic flag_n_q, flag_n_d, flag_z_q, flag_z_d;
    logic [15:0] pc_q, pc_d;
    logic [STK_AW-1:0] sp_q, sp_d;
    logic ready_q, ready_d;
    logic [11:0] move_src_q, move_src_d;
    logic move_ss_q, move_ss_d;
    logic ext_en_q, ext_en_d, fuse_cap_q, fuse_cap_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic hreadyout_q, hresp_q;

    logic mem_we, stk_we;
    logic [11:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [STK_AW-1:0] stk_widx, sp_dec;
    logic [15:0] stk_wdata;

    logic take, bus_take, is_pfx;
    logic is_or_lit, is_or_reg, is_mul_lit, is_mul_reg;
    logic is_call, is_addp, is_subp, is_push, is_move;
    logic [7:0] opnd, res_or, res_lit, move_byte;
    logic [15:0] prod_lit, prod_reg, call_target;
    logic [11:0] opnd_addr, ptr2_now, move_dst, lit6_ext;
    logic [1:0] pidx;

    omed_addr_if u_addr_if ();
    omed_addr_gen u_addr_gen (
        .ai(u_addr_if.gen)
    );
    assign u_addr_if.f = I_INSTR[7:0];
    assign u_addr_if.a = I_INSTR[8];
    assign u_addr_if.ext_en = ext_en_q;
    assign u_addr_if.bank = bank_q[3:0];
    assign u_addr_if.ptr2 = ptr_q[omed_pkg::PTR_TWO];

    always_comb begin
        take = I_INSTR_VALID && ready_q;
        bus_take = I_HSEL && I_HTRANS[1] && I_HREADY;
        opnd_addr = u_addr_if.addr;
        opnd = dmem[opnd_addr];
        ptr2_now = ptr_q[omed_pkg::PTR_TWO];
        is_pfx = (I_INSTR[15:12] == omed_pkg::PFX_SECOND);
        is_or_lit = (I_INSTR[15:8] == omed_pkg::OP_OR_LIT);
        is_or_reg = (I_INSTR[15:10] == omed_pkg::OP_OR_REG);
        is_mul_lit = (I_INSTR[15:8] == omed_pkg::OP_MUL_LIT);
        is_mul_reg = (I_INSTR[15:9] == omed_pkg::OP_MUL_REG);
        // The eight added words decode only while the extension is on.
        is_call = ext_en_q && (I_INSTR == omed_pkg::OP_CALL_ACC);
        is_addp = ext_en_q && (I_INSTR[15:8] == omed_pkg::OP_ADD_PTR);
        is_subp = ext_en_q && (I_INSTR[15:8] == omed_pkg::OP_SUB_PTR);
        is_push = ext_en_q && (I_INSTR[15:8] == omed_pkg::OP_PUSH);
        is_move = ext_en_q && (I_INSTR[15:8] == omed_pkg::OP_MOVE);
        res_or = acc_q | opnd;
        res_lit = acc_q | I_INSTR[7:0];
        prod_lit = {8'h00, acc_q} * {8'h00, I_INSTR[7:0]};
        prod_reg = {8'h00, acc_q} * {8'h00, opnd};
        call_target = {call_hi_q, acc_q};
        lit6_ext = {6'h00, I_INSTR[5:0]};
        pidx = (I_INSTR[7:6] == omed_pkg::SEL_RETURN) ? omed_pkg::PTR_TWO
                                                      : I_INSTR[7:6];
        move_byte = dmem[move_src_q];
        if (move_ss_q) begin
            move_dst = ptr2_now + {5'h00, I_INSTR[6:0]};
        end else begin
            move_dst = I_INSTR[11:0];
        end
        sp_dec = sp_q - STK_ONE;
    end

    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        bank_d = bank_q;
        call_hi_d = call_hi_q;
        product_high_byte_d = product_high_byte_q;
        product_low_byte_d = product_low_byte_q;
        ptr_d = ptr_q;
        flag_n_d = flag_n_q;
        flag_z_d = flag_z_q;
        pc_d = pc_q;
        sp_d = sp_q;
        ready_d = 1'b1;
        move_src_d = move_src_q;
        move_ss_d = move_ss_q;
        ext_en_d = ext_en_q;
        fuse_cap_d = 1'b1;
        mem_we = 1'b0;
        mem_waddr = opnd_addr;
        mem_wdata = res_or;
        stk_we = 1'b0;
        stk_widx = sp_q;
        stk_wdata = pc_q + 16'h0001;
        if (!fuse_cap_q) begin
            ext_en_d = I_EXT_FUSE;
        end
        if (take) begin
            pc_d = pc_q + 16'h0001;
            state_d = omed_pkg::OMED_RUN;
            if (state_q == omed_pkg::OMED_MOVE_WAIT && is_pfx) begin
                mem_we = 1'b1;
                mem_waddr = move_dst;
                mem_wdata = move_byte;
            end else if (is_or_lit) begin
                acc_d = res_lit;
                flag_n_d = res_lit[7];
                flag_z_d = (res_lit == 8'h00);
            end else if (is_or_reg) begin
                if (I_INSTR[9]) begin
                    mem_we = 1'b1;
                end else begin
                    acc_d = res_or;
                end
                flag_n_d = res_or[7];
                flag_z_d = (res_or == 8'h00);
            end else if (is_mul_lit) begin
                // Flags are deliberately not touched by either multiply.
                {product_high_byte_d, product_low_byte_d} = prod_lit;
            end else if (is_mul_reg) begin
                {product_high_byte_d, product_low_byte_d} = prod_reg;
            end else if (is_call) begin
                stk_we = 1'b1;
                sp_d = sp_q + STK_ONE;
                pc_d = call_target;
                ready_d = 1'b0;
            end else if (is_addp || is_subp) begin
                if (is_addp) begin
                    ptr_d[pidx] = ptr_q[pidx] + lit6_ext;
                end else begin
                    ptr_d[pidx] = ptr_q[pidx] - lit6_ext;
                end
                if (I_INSTR[7:6] == omed_pkg::SEL_RETURN) begin
                    // The return costs the second cycle; flags stay put.
                    pc_d = stk_mem[sp_dec];
                    sp_d = sp_dec;
                    ready_d = 1'b0;
                end
            end else if (is_push) begin
                mem_we = 1'b1;
                mem_waddr = ptr2_now;
                mem_wdata = I_INSTR[7:0];
                ptr_d[omed_pkg::PTR_TWO] = ptr2_now - 12'h001;
            end else if (is_move) begin
                move_src_d = ptr2_now + {5'h00, I_INSTR[6:0]};
                move_ss_d = I_INSTR[7];
                state_d = omed_pkg::OMED_MOVE_WAIT;
            end
            // Anything else, a lone second word included, is a no-op.
        end
        // A bus write lands after execution, so the bus write wins a collision.
        if (wr_pend_q) begin
            case (wr_addr_q)
                omed_pkg::OFS_ACC: acc_d = I_HWDATA[7:0];
                omed_pkg::OFS_BANK: bank_d = I_HWDATA[7:0];
                omed_pkg::OFS_PTR0: ptr_d[0] = I_HWDATA[11:0];
                omed_pkg::OFS_PTR1: ptr_d[1] = I_HWDATA[11:0];
                omed_pkg::OFS_PTR2: ptr_d[2] = I_HWDATA[11:0];
                omed_pkg::OFS_CALL_HI: call_hi_d = I_HWDATA[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        wr_pend_d = bus_take && I_HWRITE;
        wr_addr_d = (I_HADDR[31:8] == 24'h000000) ? I_HADDR[7:0] : 8'hFF;
        hrdata_d = hrdata_q;
        // Reads sample next-state values so a write just before is seen.
        if (bus_take && !I_HWRITE) begin
            hrdata_d = 32'h00000000;
            if (I_HADDR[31:8] == 24'h000000) begin
                case (I_HADDR[7:0])
                    omed_pkg::OFS_ACC: hrdata_d[7:0] = acc_d;
                    omed_pkg::OFS_BANK: hrdata_d[7:0] = bank_d;
                    omed_pkg::OFS_PROD: hrdata_d[15:0] = {product_high_byte_d, product_low_byte_d};
                    omed_pkg::OFS_PTR0: hrdata_d[11:0] = ptr_d[0];
                    omed_pkg::OFS_PTR1: hrdata_d[11:0] = ptr_d[1];
                    omed_pkg::OFS_PTR2: hrdata_d[11:0] = ptr_d[2];
                    omed_pkg::OFS_STATUS: begin
                        hrdata_d[omed_pkg::ST_Z_BIT] = flag_z_d;
                        hrdata_d[omed_pkg::ST_N_BIT] = flag_n_d;
                        hrdata_d[omed_pkg::ST_EXT_BIT] = ext_en_d;
                    end
                    omed_pkg::OFS_PC: hrdata_d[15:0] = pc_d;
                    omed_pkg::OFS_CALL_HI: hrdata_d[7:0] = call_hi_d;
                    default: hrdata_d = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_q <= omed_pkg::OMED_RUN;
            acc_q <= omed_pkg::RST_BYTE;
            bank_q <= omed_pkg::RST_BYTE;
            call_hi_q <= omed_pkg::RST_BYTE;
            product_high_byte_q <= omed_pkg::RST_BYTE;
            product_low_byte_q <= omed_pkg::RST_BYTE;
            ptr_q <= {3{omed_pkg::RST_PTR}};
            flag_n_q <= 1'b0;
            flag_z_q <= 1'b0;
            pc_q <= omed_pkg::RST_PC;
            sp_q <= '0;
            ready_q <= 1'b0;
            move_src_q <= omed_pkg::RST_PTR;
            move_ss_q <= 1'b0;
            ext_en_q <= omed_pkg::EXT_DEFAULT;
            fuse_cap_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= omed_pkg::RST_BYTE;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            bank_q <= bank_d;
            call_hi_q <= call_hi_d;
            product_high_byte_q <= product_high_byte_d;
            product_low_byte_q <= product_low_byte_d;
            ptr_q <= ptr_d;
            flag_n_q <= flag_n_d;
            flag_z_q <= flag_z_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            ready_q <= ready_d;
            move_src_q <= move_src_d;
            move_ss_q <= move_ss_d;
            ext_en_q <= ext_en_d;
            fuse_cap_q <= fuse_cap_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (mem_we) begin
            dmem[mem_waddr] <= mem_wdata;
        end
        if (stk_we) begin
            stk_mem[stk_widx] <= stk_wdata;
        end
    end

    assign O_INSTR_READY = ready_q;
    assign O_PC = pc_q;
    assign O_EXT_ENABLED = ext_en_q;
    assign O_HRDATA = hrdata_q;
    assign O_HREADYOUT = hreadyout_q;
    assign O_HRESP = hresp_q;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_NRST);

    or_literal_a: assert property (take && is_or_lit && !wr_pend_q |=>
        acc_q == $past(res_lit) && flag_n_q == acc_q[7] &&
        flag_z_q == (acc_q == 8'h00))
        else $error("literal OR result or flags wrong");
    or_dest_mem_a: assert property (take && is_or_reg && I_INSTR[9] &&
        state_q == omed_pkg::OMED_RUN && !wr_pend_q |=>
        $stable(acc_q) && dmem[$past(opnd_addr)] == $past(res_or))
        else $error("register OR to memory wrong");
    index_addr_a: assert property (ext_en_q && !I_INSTR[8] &&
        I_INSTR[7:0] <= omed_pkg::ACCESS_LIMIT |->
        opnd_addr == ptr2_now + {4'h0, I_INSTR[7:0]})
        else $error("indexed operand address wrong");
    bank_addr_a: assert property (I_INSTR[8] |->
        opnd_addr == {bank_q[3:0], I_INSTR[7:0]})
        else $error("banked operand address wrong");
    mul_literal_a: assert property (take && is_mul_lit &&
        state_q == omed_pkg::OMED_RUN |=>
        {product_high_byte_q, product_low_byte_q} == $past(prod_lit) && $stable(flag_z_q) &&
        $stable(flag_n_q))
        else $error("literal product or flags wrong");
    mul_reg_keep_a: assert property (take && is_mul_reg && !wr_pend_q &&
        state_q == omed_pkg::OMED_RUN |=>
        {product_high_byte_q, product_low_byte_q} == $past(prod_reg) && $stable(acc_q) &&
        dmem[$past(opnd_addr)] == $past(opnd))
        else $error("register multiply disturbed operands");
    mul_flags_a: assert property (take && (is_mul_lit || is_mul_reg) |=>
        $stable(flag_z_q) && $stable(flag_n_q))
        else $error("multiply changed a flag");
    ret_stall_a: assert property (take && (is_addp || is_subp) &&
        I_INSTR[7:6] == omed_pkg::SEL_RETURN &&
        state_q == omed_pkg::OMED_RUN |=>
        !ready_q && pc_q == $past(stk_mem[sp_dec]) ##1 ready_q)
        else $error("pointer return not two cycles");
    call_acc_a: assert property (take && is_call &&
        state_q == omed_pkg::OMED_RUN |=>
        pc_q == $past(call_target) && !ready_q ##1 ready_q)
        else $error("accumulator call wrong");
    push_lit_a: assert property (take && is_push && !wr_pend_q &&
        state_q == omed_pkg::OMED_RUN |=>
        ptr2_now == $past(ptr2_now) - 12'h001 &&
        dmem[$past(ptr2_now)] == $past(I_INSTR[7:0]) && ready_q)
        else $error("literal push wrong");
    move_done_a: assert property (take && is_pfx &&
        state_q == omed_pkg::OMED_MOVE_WAIT |=>
        dmem[$past(move_dst)] == $past(move_byte) &&
        state_q == omed_pkg::OMED_RUN)
        else $error("two-word move wrong");
    fuse_off_a: assert property (take && !ext_en_q && I_INSTR[15:12] ==
        4'hE && !wr_pend_q |=> $stable(ptr_q) &&
        state_q == omed_pkg::OMED_RUN)
        else $error("extension ran while disabled");
    lone_word_a: assert property (take && is_pfx && !wr_pend_q &&
        state_q == omed_pkg::OMED_RUN |=> $stable(acc_q) &&
        $stable(ptr_q) && $stable(product_low_byte_q))
        else $error("lone second word had an effect");

    call_seen_c: cover property (take && is_call);
    move_seen_c: cover property (state_q == omed_pkg::OMED_MOVE_WAIT ##1
        state_q == omed_pkg::OMED_RUN);
    mul_reg_seen_c: cover property (take && is_mul_reg);
    sub_ret_seen_c: cover property (take && is_subp &&
        I_INSTR[7:6] == omed_pkg::SEL_RETURN);
endmodule
`default_nettype wire

//--- rtl/omed_pkg.sv
`default_nettype none
package omed_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int PC_W = 16;
    localparam int INSTR_W = 16;
    localparam int LIT6_W = 6;
    localparam int OFS7_W = 7;

    typedef enum logic [0:0] {OMED_RUN, OMED_MOVE_WAIT} omed_state_t;

    // Register byte addresses on the bus, one aligned word each.
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_BANK = 8'h04;
    localparam logic [7:0] OFS_PROD = 8'h08;
    localparam logic [7:0] OFS_PTR0 = 8'h0C;
    localparam logic [7:0] OFS_PTR1 = 8'h10;
    localparam logic [7:0] OFS_PTR2 = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_PC = 8'h1C;
    localparam logic [7:0] OFS_CALL_HI = 8'h20;

    localparam int ST_Z_BIT = 0;
    localparam int ST_N_BIT = 1;
    localparam int ST_EXT_BIT = 8;

    // Opcode fields.
    localparam logic [7:0] OP_OR_LIT = 8'h09;
    localparam logic [7:0] OP_MUL_LIT = 8'h0D;
    localparam logic [6:0] OP_MUL_REG = 7'h01;
    localparam logic [5:0] OP_OR_REG = 6'h04;
    localparam logic [15:0] OP_CALL_ACC = 16'h0014;
    localparam logic [7:0] OP_ADD_PTR = 8'hE8;
    localparam logic [7:0] OP_SUB_PTR = 8'hE9;
    localparam logic [7:0] OP_PUSH = 8'hEA;
    localparam logic [7:0] OP_MOVE = 8'hEB;
    localparam logic [3:0] PFX_SECOND = 4'hF;

    localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [1:0] SEL_RETURN = 2'h3;
    localparam logic [1:0] PTR_TWO = 2'h2;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_PTR = 12'h000;
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic EXT_DEFAULT = 1'b1;
endpackage
`default_nettype wire

//--- sim/omed_fetch_model.sv
`timescale 1ns/1ns
`default_nettype none
module omed_fetch_model (
    input wire logic i_clk, // Core clock.
    input wire logic i_ready, // Word taken when valid.
    output logic o_valid, // Word on offer.
    output logic [15:0] o_instr // Offered word.
);
    initial begin
        o_valid = 1'b0;
        o_instr = 16'h0000;
    end
    // Call just after a rising edge; the word stands until it is taken.
    task automatic issue(input logic [15:0] w);
        o_valid <= 1'b1;
        o_instr <= w;
        do @(posedge i_clk); while (i_ready !== 1'b1);
    endtask
    // A released word is inverted so a stale value never passes as fresh.
    task automatic idle(input int n);
        o_valid <= 1'b0;
        o_instr <= ~o_instr;
        repeat (n) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

//--- sim/or_multiply_extended_decode_test.sv
`timescale 1ns/1ns
`default_nettype none
module or_multiply_extended_decode_test;
    typedef struct packed {
        logic [7:0] pre_ofs;
        logic [31:0] pre_val;
        logic [15:0] instr;
        logic [7:0] ofs;
        logic [31:0] exp;
    } omed_row_t;
    localparam logic [7:0] ACC = omed_pkg::OFS_ACC;
    localparam logic [7:0] ST = omed_pkg::OFS_STATUS;
    localparam logic [7:0] PRD = omed_pkg::OFS_PROD;
    localparam logic [7:0] P0 = omed_pkg::OFS_PTR0;
    localparam logic [7:0] P1 = omed_pkg::OFS_PTR1;
    localparam logic [7:0] P2 = omed_pkg::OFS_PTR2;
    localparam logic [7:0] PCR = omed_pkg::OFS_PC;
    logic clk = 1'b0, nrst = 1'b0, fuse = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic valid, ready, hready, hresp, ext;
    logic [15:0] instr, pc;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, pc0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    int fail_count = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    omed_core i_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_EXT_FUSE(fuse),
        .I_INSTR_VALID(valid), .I_INSTR(instr), .O_INSTR_READY(ready),
        .O_PC(pc), .O_EXT_ENABLED(ext), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp));
    omed_fetch_model i_fetch (.i_clk(clk), .i_ready(ready), .o_valid(valid),
        .o_instr(instr));
    // Rows run in order: later rows lean on memory and flags left by earlier.
    localparam omed_row_t ROWS [18] = '{
        '{ACC, 32'h9A, 16'h0935, ACC, 32'hBF},
        '{ACC, 32'h9A, 16'h0935, ST, 32'h102},
        '{ACC, 32'h00, 16'h0900, ST, 32'h101},
        '{ACC, 32'hE2, 16'h0DC4, PRD, 32'hAD08},
        '{ACC, 32'h80, 16'h0D00, ST, 32'h101},
        '{ACC, 32'h55, 16'h0D02, ACC, 32'h55},
        '{P0, 32'h100, 16'hE805, P0, 32'h105},
        '{P1, 32'h010, 16'hE953, P1, 32'hFFD},
        '{P2, 32'h050, 16'hEAB5, P2, 32'h04F},
        '{ACC, 32'hC4, 16'h0350, PRD, 32'h8A94},
        '{ACC, 32'hC4, 16'h0350, ACC, 32'hC4},
        '{ACC, 32'hC4, 16'h0201, PRD, 32'h8A94},
        '{ACC, 32'h02, 16'h1150, ACC, 32'hB7},
        '{ACC, 32'h40, 16'h1350, ACC, 32'h40},
        '{ACC, 32'h01, 16'h0350, PRD, 32'hF5},
        '{ACC, 32'h33, 16'hF123, ACC, 32'h33},
        '{P2, 32'hF60, 16'hEA7E, P2, 32'hF5F},
        '{ACC, 32'h02, 16'h0260, PRD, 32'hFC}
    };
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        htrans <= 2'h2;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic run(input logic [15:0] w);
        i_fetch.issue(w);
        i_fetch.idle(2);
    endtask
    // The offer is withdrawn at once, or the word would be taken twice.
    task automatic two_cycle(input logic [15:0] w);
        i_fetch.issue(w);
        i_fetch.idle(0);
        #1 chk({31'h0, ready}, 32'h0);
        @(posedge clk);
        #1 chk({31'h0, ready}, 32'h1);
        @(posedge clk);
    endtask
    task automatic reset_dut(input logic f);
        nrst <= 1'b0;
        fuse <= f;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        reset_dut(1'b1);
        rd_chk(ST, 32'h100);
        rd_chk(PCR, 32'h0);
        bus(1'b1, 8'h40, 32'h5A);
        rd_chk(8'h40, 32'h0);
        $display("test reset done");
        foreach (ROWS[i]) begin
            bus(1'b1, ROWS[i].pre_ofs, ROWS[i].pre_val);
            run(ROWS[i].instr);
            rd_chk(ROWS[i].ofs, ROWS[i].exp);
        end
        $display("test table done");
        bus(1'b1, omed_pkg::OFS_CALL_HI, 32'h12);
        bus(1'b1, ACC, 32'h34);
        bus(1'b1, P2, 32'h020);
        bus(1'b0, PCR, 32'h0);
        pc0 = q;
        two_cycle(16'h0014);
        rd_chk(PCR, 32'h1234);
        two_cycle(16'hE8C3);
        rd_chk(PCR, pc0 + 32'h1);
        rd_chk(P2, 32'h023);
        two_cycle(16'h0014);
        two_cycle(16'hE9C2);
        rd_chk(PCR, pc0 + 32'h2);
        rd_chk(P2, 32'h021);
        rd_chk(ST, 32'h102);
        chk({31'h0, hresp}, 32'h0);
        $display("test call and return done");
        bus(1'b1, P2, 32'h04B);
        bus(1'b1, ACC, 32'h01);
        i_fetch.issue(16'hEB05);
        run(16'hF0A0);
        run(16'h03A0);
        rd_chk(PRD, 32'hF5);
        run(16'hEB85);
        run(16'hF006);
        run(16'h0206);
        rd_chk(PRD, 32'hF5);
        $display("test moves done");
        reset_dut(1'b0);
        rd_chk(ST, 32'h000);
        chk({31'h0, ext}, 32'h0);
        bus(1'b1, P2, 32'h030);
        bus(1'b0, PCR, 32'h0);
        pc0 = q;
        run(16'hEA11);
        rd_chk(P2, 32'h030);
        rd_chk(PCR, pc0 + 32'h1);
        chk({16'h0, pc}, pc0 + 32'h1);
        $display("test fuse off done");
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
